// [core/sgcb_cfg.svh]
`ifndef SGCB_CFG_SVH
`define SGCB_CFG_SVH
`define SGCB_OFF_RUN 12'h108
`define SGCB_OFF_SLEEP 12'h114
`define SGCB_OFF_DEEP 12'h124
`define SGCB_OFF_MODE 12'h060
`define SGCB_OFF_IRQ_STAT 12'h200
`define SGCB_OFF_IRQ_MASK 12'h204
`define SGCB_GATE_MASK 32'h0707_1011
`define SGCB_GATE_RESET 32'h0000_0000
`define SGCB_BIT_AUTO 27
`define SGCB_MODE_RESET 32'h0000_0000
`define SGCB_IRQ_FAULT 0
`define SGCB_IRQ_CHANGE 1
`define SGCB_IRQ_MASK_BITS 32'h0000_0003
`endif

// [core/sgcb_pkg.sv]
package sgcb_pkg;
    typedef struct packed {
        logic comparator_two_gate;
        logic comparator_one_gate;
        logic comparator_zero_gate;
        logic gp_counter_two_gate;
        logic gp_counter_one_gate;
        logic gp_counter_zero_gate;
        logic two_wire_port_gate;
        logic sync_serial_gate;
        logic async_serial_gate;
    } sgcb_gates_t;
    typedef enum logic [1:0] {
        SGCB_RUN = 2'h0,
        SGCB_SLEEP = 2'h1,
        SGCB_DEEP = 2'h2
    } sgcb_mode_t;
endpackage

// [core/sgcb_gate_bank.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sgcb_cfg.svh"
module sgcb_gate_bank
    import sgcb_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic [1:0] power_mode_in,
    input wire logic unit_access_in,
    input wire logic [3:0] unit_index_in,
    output logic unit_fault_out,
    output sgcb_gates_t unit_clk_en_out,
    output logic irq_out
);
    logic [31:0] run_q;
    logic [31:0] sleep_q;
    logic [31:0] deep_q;
    logic [31:0] mode_reg_q;
    logic [31:0] irq_stat_q;
    logic [31:0] irq_mask_q;
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic [31:0] rdata_q;
    logic fault_q;
    logic [31:0] active_d;
    logic [31:0] active_q;
    sgcb_gates_t gates_d;

    function automatic sgcb_gates_t pack_gates(input logic [31:0] v);
        pack_gates = {v[26], v[25], v[24], v[18], v[17], v[16],
                      v[12], v[4], v[0]};
    endfunction

    function automatic logic unit_on(input logic [31:0] v,
                                     input logic [3:0] idx);
        case (idx)
            4'h0: unit_on = v[0];
            4'h1: unit_on = v[4];
            4'h2: unit_on = v[12];
            4'h3: unit_on = v[16];
            4'h4: unit_on = v[17];
            4'h5: unit_on = v[18];
            4'h6: unit_on = v[24];
            4'h7: unit_on = v[25];
            4'h8: unit_on = v[26];
            default: unit_on = 1'b0;
        endcase
    endfunction

    logic addr_ph;
    assign addr_ph = hsel_in & htrans_in[1] & hready_in;

    // writes land one cycle after the address phase; zero wait states
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else begin
            wr_pend_q <= addr_ph & hwrite_in;
            wr_addr_q <= haddr_in[11:0];
        end
    end

    // reserved bits never store, so they read as zero
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            run_q <= `SGCB_GATE_RESET;
            sleep_q <= `SGCB_GATE_RESET;
            deep_q <= `SGCB_GATE_RESET;
            mode_reg_q <= `SGCB_MODE_RESET;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                `SGCB_OFF_RUN: run_q <= hwdata_in & `SGCB_GATE_MASK;
                `SGCB_OFF_SLEEP: begin
                    sleep_q <= hwdata_in & `SGCB_GATE_MASK;
                end
                `SGCB_OFF_DEEP: deep_q <= hwdata_in & `SGCB_GATE_MASK;
                `SGCB_OFF_MODE: begin
                    mode_reg_q <= {4'h0, hwdata_in[`SGCB_BIT_AUTO], 27'h0};
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (addr_ph && !hwrite_in) begin
            case (haddr_in[11:0])
                `SGCB_OFF_RUN: rdata_q <= run_q;
                `SGCB_OFF_SLEEP: rdata_q <= sleep_q;
                `SGCB_OFF_DEEP: rdata_q <= deep_q;
                `SGCB_OFF_MODE: rdata_q <= mode_reg_q;
                `SGCB_OFF_IRQ_STAT: rdata_q <= irq_stat_q;
                `SGCB_OFF_IRQ_MASK: rdata_q <= irq_mask_q;
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // deep sleep follows the same auto select as sleep
    always_comb begin
        active_d = run_q;
        if (mode_reg_q[`SGCB_BIT_AUTO]) begin
            case (power_mode_in)
                SGCB_SLEEP: active_d = sleep_q;
                SGCB_DEEP: active_d = deep_q;
                default: active_d = run_q;
            endcase
        end
        gates_d = pack_gates(active_d);
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            active_q <= `SGCB_GATE_RESET;
            unit_clk_en_out <= '0;
        end else begin
            active_q <= active_d;
            unit_clk_en_out <= gates_d;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= unit_access_in & ~unit_on(active_q, unit_index_in);
        end
    end

    logic change_ev;
    assign change_ev = active_q != active_d;

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            irq_stat_q <= 32'h0000_0000;
            irq_mask_q <= 32'h0000_0000;
        end else begin
            if (wr_pend_q && wr_addr_q == `SGCB_OFF_IRQ_MASK) begin
                irq_mask_q <= hwdata_in & `SGCB_IRQ_MASK_BITS;
            end
            irq_stat_q <= ((wr_pend_q && wr_addr_q == `SGCB_OFF_IRQ_STAT)
                           ? irq_stat_q & ~hwdata_in : irq_stat_q)
                          | ({31'h0, fault_q} << `SGCB_IRQ_FAULT)
                          | ({31'h0, change_ev} << `SGCB_IRQ_CHANGE);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat_q & irq_mask_q);
        end
    end

    // bus answer kept in flops so every output leaves a register
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end
    end

    assign hrdata_out = rdata_q;
    assign unit_fault_out = fault_q;

    sleep_reset_a: assert property (@(posedge core_clk_in)
        !resetn_in |=> sleep_q == 32'h0000_0000 && irq_out == 1'b0)
        else $error("sleep gating not cleared by reset");

    bank_reset_a: assert property (@(posedge core_clk_in)
        !resetn_in |=> run_q == 32'h0000_0000 && deep_q == 32'h0000_0000
        && mode_reg_q == 32'h0000_0000 && unit_clk_en_out == '0)
        else $error("gating bank not cleared by reset");

    reserved_zero_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in) (sleep_q & ~32'h0707_1011) == 32'h0)
        else $error("reserved gating bit set");

    other_reserved_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        ((run_q | deep_q) & ~32'h0707_1011) == 32'h0)
        else $error("reserved run or deep bit set");

    sleep_write_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        addr_ph && hwrite_in && haddr_in[11:0] == 12'h114
        ##1 resetn_in |=> sleep_q == ($past(hwdata_in) & 32'h0707_1011))
        else $error("sleep register write lost");

    run_write_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        addr_ph && hwrite_in && haddr_in[11:0] == 12'h108
        ##1 resetn_in |=> run_q == ($past(hwdata_in) & 32'h0707_1011))
        else $error("run register write lost");

    deep_write_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        addr_ph && hwrite_in && haddr_in[11:0] == 12'h124
        ##1 resetn_in |=> deep_q == ($past(hwdata_in) & 32'h0707_1011))
        else $error("deep register write lost");

    sleep_keep_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        !(wr_pend_q && wr_addr_q == 12'h114) |=> sleep_q == $past(sleep_q))
        else $error("sleep register changed without write");

    sleep_read_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        addr_ph && !hwrite_in && haddr_in[11:0] == 12'h114
        |=> hrdata_out == $past(sleep_q))
        else $error("sleep register read wrong");

    auto_sleep_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        mode_reg_q[27] && power_mode_in == 2'h1
        |=> active_q == $past(sleep_q))
        else $error("sleep gating not applied");

    auto_deep_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        mode_reg_q[27] && power_mode_in == 2'h2
        |=> active_q == $past(deep_q))
        else $error("deep gating not applied");

    run_mode_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        power_mode_in == 2'h0 |=> active_q == $past(run_q))
        else $error("run gating not used in run mode");

    no_auto_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        !mode_reg_q[27] |=> active_q == $past(run_q))
        else $error("run gating not kept");

    timer_bit_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        ##1 unit_clk_en_out.gp_counter_one_gate == $past(active_d[17]))
        else $error("timer one enable wrong");

    timer_zero_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        ##1 unit_clk_en_out.gp_counter_zero_gate == $past(active_d[16]))
        else $error("timer zero enable wrong");

    timer_two_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        ##1 unit_clk_en_out.gp_counter_two_gate == $past(active_d[18]))
        else $error("timer two enable wrong");

    two_wire_bit_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        ##1 unit_clk_en_out.two_wire_port_gate == $past(active_d[12]))
        else $error("two-wire enable wrong");

    sync_bit_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        ##1 unit_clk_en_out.sync_serial_gate == $past(active_d[4]))
        else $error("sync serial enable wrong");

    uart_bit_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        ##1 unit_clk_en_out.async_serial_gate == $past(active_d[0]))
        else $error("uart enable wrong");

    comp_bit_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        ##1 unit_clk_en_out.comparator_two_gate == $past(active_d[26]))
        else $error("comparator two enable wrong");

    comp_zero_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        ##1 unit_clk_en_out.comparator_zero_gate == $past(active_d[24]))
        else $error("comparator zero enable wrong");

    comp_one_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        ##1 unit_clk_en_out.comparator_one_gate == $past(active_d[25]))
        else $error("comparator one enable wrong");

    fault_gate_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        unit_access_in && unit_index_in == 4'h2 && !active_q[12]
        |=> unit_fault_out ##1 irq_stat_q[0])
        else $error("gated access not faulted");

    ssi_fault_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        unit_access_in && unit_index_in == 4'h1 && active_q[4]
        |=> !unit_fault_out)
        else $error("clocked access faulted");

    uart_fault_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        unit_access_in && unit_index_in == 4'h0 && !active_q[0]
        |=> unit_fault_out)
        else $error("gated uart access not faulted");

    bad_index_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        unit_access_in && unit_index_in > 4'h8 |=> unit_fault_out)
        else $error("unknown unit access not faulted");

    no_access_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        !unit_access_in |=> !unit_fault_out)
        else $error("fault without access");

    irq_level_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        (irq_stat_q & irq_mask_q) != 32'h0 |=> irq_out)
        else $error("unmasked status without interrupt");

    bus_okay_a: assert property (@(posedge core_clk_in)
        disable iff (!resetn_in)
        ##1 hreadyout_out && !hresp_out)
        else $error("register bus not ready or okay");

endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sgcb_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t got %h want %h", $time, (g), (e)); end end
module testbench
    import sgcb_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [1:0] pmode = 2'h0;
    logic uacc = 1'b0;
    logic [3:0] uidx = 4'h0;
    logic ufault;
    sgcb_gates_t gates;
    logic irq;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int pos[9] = '{0, 4, 12, 16, 17, 18, 24, 25, 26};
    logic [31:0] rd;
    sgcb_gate_bank u_dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .power_mode_in(pmode), .unit_access_in(uacc),
        .unit_index_in(uidx), .unit_fault_out(ufault),
        .unit_clk_en_out(gates), .irq_out(irq));
    always #10 core_clk_in = ~core_clk_in;
    task automatic tally_and_finish();
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ceiling well above the few hundred cycles the sequence needs
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            $display("[FAIL] %0t timeout", $time);
            tally_and_finish();
        end
    end
    task automatic bus(input logic [11:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge core_clk_in);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge core_clk_in); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk_in); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(a, 1'b1, d, dummy);
        // gates land one edge and irq up to two edges after the data phase
        repeat (2) @(posedge core_clk_in);
        #1;
    endtask
    task automatic unit_hit(input logic [3:0] k, input logic e);
        @(posedge core_clk_in);
        uacc <= 1'b1;
        uidx <= k;
        @(posedge core_clk_in);
        uacc <= 1'b0;
        #1;
        `CHK(ufault, e)
    endtask
    initial begin
        repeat (20) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        #1;
        `CHK(gates, 9'h000)
        bus(`SGCB_OFF_SLEEP, 1'b0, 32'h0, rd);
        `CHK(rd, `SGCB_GATE_RESET)
        unit_hit(4'h0, 1'b1);
        wr(`SGCB_OFF_MODE, 32'h0800_0000);
        bus(`SGCB_OFF_MODE, 1'b0, 32'h0, rd);
        `CHK(rd, 32'h0800_0000)
        pmode <= 2'h1;
        for (int i = 0; i < 9; i++) begin
            wr(`SGCB_OFF_SLEEP, 32'h1 << pos[i]);
            `CHK(gates, 9'h001 << i)
            unit_hit(4'(i), 1'b0);
            unit_hit(4'((i + 1) % 9), 1'b1);
        end
        wr(`SGCB_OFF_SLEEP, 32'hffff_ffff);
        bus(`SGCB_OFF_SLEEP, 1'b0, 32'h0, rd);
        `CHK(rd, 32'h0707_1011)
        `CHK(gates, 9'h1ff)
        unit_hit(4'h9, 1'b1);
        wr(`SGCB_OFF_MODE, 32'h0);
        `CHK(gates, 9'h000)
        wr(`SGCB_OFF_MODE, 32'h0800_0000);
        wr(`SGCB_OFF_DEEP, 32'h0000_1000);
        pmode <= 2'h2;
        wr(`SGCB_OFF_RUN, 32'h0000_0001);
        `CHK(gates, 9'h004)
        bus(`SGCB_OFF_RUN, 1'b0, 32'h0, rd);
        `CHK(rd, 32'h0000_0001)
        bus(`SGCB_OFF_DEEP, 1'b0, 32'h0, rd);
        `CHK(rd, 32'h0000_1000)
        pmode <= 2'h0;
        repeat (2) @(posedge core_clk_in);
        #1;
        `CHK(gates, 9'h001)
        bus(`SGCB_OFF_SLEEP, 1'b0, 32'h0, rd);
        `CHK(rd, 32'h0707_1011)
        wr(12'h300, 32'hffff_ffff);
        bus(12'h300, 1'b0, 32'h0, rd);
        `CHK(rd, 32'h0)
        wr(`SGCB_OFF_IRQ_MASK, 32'h1);
        bus(`SGCB_OFF_IRQ_STAT, 1'b0, 32'h0, rd);
        `CHK(rd[1], 1'b1)
        wr(`SGCB_OFF_IRQ_STAT, 32'h3);
        `CHK(irq, 1'b0)
        unit_hit(4'h2, 1'b1);
        repeat (3) @(posedge core_clk_in);
        #1;
        `CHK(irq, 1'b1)
        bus(`SGCB_OFF_IRQ_STAT, 1'b0, 32'h0, rd);
        `CHK(rd[0], 1'b1)
        wr(`SGCB_OFF_IRQ_MASK, 32'h0);
        `CHK(irq, 1'b0)
        wr(`SGCB_OFF_IRQ_MASK, 32'h1);
        `CHK(irq, 1'b1)
        wr(`SGCB_OFF_IRQ_STAT, 32'h1);
        `CHK(irq, 1'b0)
        `CHK(hresp, 1'b0)
        tally_and_finish();
    end
endmodule
`default_nettype wire
